// file: deser_interrupt_aggregator.sv
// interrupt aggregation for the single-port deserializer: flags, enables, summary and output pins
`timescale 1ns/10ps
module deser_interrupt_aggregator
  import deser_irq_pkg::*;
#(
  parameter int GPIO_CNT = deser_irq_pkg::NUM_GPIO
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire deser_irq_pkg::reg_req_t regReq,
  output logic [deser_irq_pkg::DATA_W-1:0] regRdData,
  output logic regRdValid,
  input wire deser_irq_pkg::rx_events_t rxEvents,
  input wire logic [deser_irq_pkg::VIN_ERR_W-1:0] videoInErr,
  input wire logic [31:0] sensorStatus,
  input wire logic rxLockPin,
  input wire logic rxPassPin,
  input wire logic [GPIO_CNT-1:0] remoteGpio,
  output logic irq_out_n,
  output logic [GPIO_CNT-1:0] gpioOut,
  output logic [GPIO_CNT-1:0] gpioOe
);
  import deser_irq_pkg::*;

  // clear-then-set update: a new event in the clearing cycle survives
  // so a status read never loses an event that lands on its clearing edge
  function automatic logic [7:0] flagUpd(input logic [7:0] old, input logic [7:0] set,
                                         input logic clr);
    flagUpd = (clr ? RST_BYTE : old) | set;
  endfunction : flagUpd

  // rising and falling edge detection from a registered previous value
  // the previous value is a flop on core_clk, so both helpers see one consistent sample
  function automatic logic [7:0] riseOf(input logic [7:0] now, input logic [7:0] prev);
    riseOf = now & ~prev;
  endfunction : riseOf

  function automatic logic [7:0] fallOf(input logic [7:0] now, input logic [7:0] prev);
    fallOf = ~now & prev;
  endfunction : fallOf

  // synchronisers and edge history
  // sensor status already lives on core_clk, so it is sampled without a synchroniser
  logic lockS1_ff, lockS2_ff, passS1_ff, passS2_ff;
  logic [GPIO_CNT-1:0] gpioS1_ff, gpioS2_ff, gpioPrev_ff;
  logic lockPrev_ff, passPrev_ff, rxIrqPrev_ff;
  logic [7:0] senPrev_ff;
  logic nxt_lockS1, nxt_lockS2, nxt_passS1, nxt_passS2;
  logic [GPIO_CNT-1:0] nxt_gpioS1, nxt_gpioS2, nxt_gpioPrev;
  logic nxt_lockPrev, nxt_passPrev, nxt_rxIrqPrev;
  logic [7:0] nxt_senPrev;
  logic rxIrq;

  // pins cross in through two flops; at 50 ns sampling, pulses longer than 50 ns
  // are seen at least once, shorter ones may slip between samples
  always_comb begin
    nxt_lockS1 = rxLockPin;
    nxt_lockS2 = lockS1_ff;
    nxt_passS1 = rxPassPin;
    nxt_passS2 = passS1_ff;
    nxt_gpioS1 = remoteGpio;
    nxt_gpioS2 = gpioS1_ff;
    nxt_gpioPrev = gpioS2_ff;
    nxt_lockPrev = lockS2_ff;
    nxt_passPrev = passS2_ff;
    nxt_senPrev = sensorStatus[7:0];
    nxt_rxIrqPrev = rxIrq;
  end

  // every chain resets to the idle low level, so a pin already high at reset release gives one edge
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lockS1_ff <= 1'b0;
      lockS2_ff <= 1'b0;
      passS1_ff <= 1'b0;
      passS2_ff <= 1'b0;
      gpioS1_ff <= '0;
      gpioS2_ff <= '0;
      gpioPrev_ff <= '0;
      lockPrev_ff <= 1'b0;
      passPrev_ff <= 1'b0;
      senPrev_ff <= RST_BYTE;
      rxIrqPrev_ff <= 1'b0;
    end else begin
      lockS1_ff <= nxt_lockS1;
      lockS2_ff <= nxt_lockS2;
      passS1_ff <= nxt_passS1;
      passS2_ff <= nxt_passS2;
      gpioS1_ff <= nxt_gpioS1;
      gpioS2_ff <= nxt_gpioS2;
      gpioPrev_ff <= nxt_gpioPrev;
      lockPrev_ff <= nxt_lockPrev;
      passPrev_ff <= nxt_passPrev;
      senPrev_ff <= nxt_senPrev;
      rxIrqPrev_ff <= nxt_rxIrqPrev;
    end
  end

  // software-written control registers
  // a write lands at its taking edge; the interrupt output follows one cycle later
  logic [7:0] ctl_ff, icrHi_ff, icrLo_ff, voutIcr_ff, gpioIcr_ff, riseMask_ff, fallMask_ff;
  logic [GPIO_CNT-1:0] pinSel_ff;
  logic [7:0] nxt_ctl, nxt_icrHi, nxt_icrLo, nxt_voutIcr, nxt_gpioIcr;
  logic [7:0] nxt_riseMask, nxt_fallMask;
  logic [GPIO_CNT-1:0] nxt_pinSel;

  // plain read/write storage; writes to status or unmapped offsets are dropped
  always_comb begin
    nxt_ctl = ctl_ff;
    nxt_icrHi = icrHi_ff;
    nxt_icrLo = icrLo_ff;
    nxt_voutIcr = voutIcr_ff;
    nxt_gpioIcr = gpioIcr_ff;
    nxt_riseMask = riseMask_ff;
    nxt_fallMask = fallMask_ff;
    nxt_pinSel = pinSel_ff;
    if (regReq.wr) begin
      unique case (regReq.addr)
        ADDR_IRQ_CONTROL: nxt_ctl = regReq.wdata;
        ADDR_RX_IRQ_ENABLE_HIGH: nxt_icrHi = regReq.wdata;
        ADDR_RX_IRQ_ENABLE_LOW: nxt_icrLo = regReq.wdata;
        ADDR_VOUT_IRQ_ENABLE: nxt_voutIcr = regReq.wdata;
        ADDR_GPIO_EDGE_ENABLE: nxt_gpioIcr = regReq.wdata;
        ADDR_SENSOR_RISE_MASK: nxt_riseMask = regReq.wdata;
        ADDR_SENSOR_FALL_MASK: nxt_fallMask = regReq.wdata;
        ADDR_PIN_OUTPUT_SELECT: nxt_pinSel = regReq.wdata[GPIO_CNT-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctl_ff <= RST_BYTE;
      icrHi_ff <= RST_BYTE;
      icrLo_ff <= RST_BYTE;
      voutIcr_ff <= RST_BYTE;
      gpioIcr_ff <= RST_BYTE;
      riseMask_ff <= RST_BYTE;
      fallMask_ff <= RST_BYTE;
      pinSel_ff <= '0;
    end else begin
      ctl_ff <= nxt_ctl;
      icrHi_ff <= nxt_icrHi;
      icrLo_ff <= nxt_icrLo;
      voutIcr_ff <= nxt_voutIcr;
      gpioIcr_ff <= nxt_gpioIcr;
      riseMask_ff <= nxt_riseMask;
      fallMask_ff <= nxt_fallMask;
      pinSel_ff <= nxt_pinSel;
    end
  end

  // sticky event flags
  // sts1 group: {passChg, bccCrc, lockChg, bccSeq, parity}
  // sts2 group: {lineLenChg, encode, buffer, lineCntChg}
  logic [7:0] sts1Flags_ff, sts2Flags_ff, vinFlags_ff, gpioFlags_ff;
  logic [7:0] riseFlags_ff, fallFlags_ff, voutFlags_ff;
  logic [7:0] nxt_sts1Flags, nxt_sts2Flags, nxt_vinFlags, nxt_gpioFlags;
  logic [7:0] nxt_riseFlags, nxt_fallFlags, nxt_voutFlags;
  logic rdSts1, rdSts2, rdVin, rdGpio, rdRise, rdFall, rdVout;
  logic [7:0] gpioNow, gpioOld, gpioHit, senRise, senFall;
  logic [7:0] set1, set2, setVin, setVout;

  localparam int F1_PARITY = 0;
  localparam int F1_SEQ = 1;
  localparam int F1_LOCKCHG = 2;
  localparam int F1_CRC = 3;
  localparam int F1_PASSCHG = 4;
  localparam int F2_LINECNT = 0;
  localparam int F2_BUFFER = 1;
  localparam int F2_ENCODE = 2;
  localparam int F2_LINELEN = 3;

  // a read clears only the register it addresses, mirrors are excluded
  assign rdSts1 = regReq.rd && (regReq.addr == ADDR_RX_STATUS_ONE);
  assign rdSts2 = regReq.rd && (regReq.addr == ADDR_RX_STATUS_TWO);
  assign rdVin = regReq.rd && (regReq.addr == ADDR_VIDEO_IN_ERROR);
  assign rdGpio = regReq.rd && (regReq.addr == ADDR_GPIO_EDGE_STATUS);
  assign rdRise = regReq.rd && (regReq.addr == ADDR_SENSOR_RISE_FLAGS);
  assign rdFall = regReq.rd && (regReq.addr == ADDR_SENSOR_FALL_FLAGS);
  assign rdVout = regReq.rd && (regReq.addr == ADDR_VOUT_IRQ_STATUS);

  // edge detection and flag capture; only the GPIO edge enable and the sensor masks gate the capture
  always_comb begin
    gpioNow = RST_BYTE;
    gpioOld = RST_BYTE;
    gpioNow[GPIO_CNT-1:0] = gpioS2_ff;
    gpioOld[GPIO_CNT-1:0] = gpioPrev_ff;
    // low nibble of the enable picks rising, high nibble falling edges
    // the enable is split in nibbles, so more than four pins needs a wider register
    gpioHit = (riseOf(gpioNow, gpioOld) & {RST_NIBBLE, gpioIcr_ff[3:0]}) |
              (fallOf(gpioNow, gpioOld) & {RST_NIBBLE, gpioIcr_ff[7:4]});
    senRise = riseOf(sensorStatus[7:0], senPrev_ff) & riseMask_ff;
    senFall = fallOf(sensorStatus[7:0], senPrev_ff) & fallMask_ff;
    set1 = RST_BYTE;
    set1[F1_PARITY] = rxEvents.parityErr;
    set1[F1_SEQ] = rxEvents.bccSeqErr;
    set1[F1_LOCKCHG] = lockS2_ff ^ lockPrev_ff;
    set1[F1_CRC] = rxEvents.bccCrcErr;
    set1[F1_PASSCHG] = passS2_ff ^ passPrev_ff;
    set2 = RST_BYTE;
    set2[F2_LINECNT] = rxEvents.lineCntChg;
    set2[F2_BUFFER] = rxEvents.bufferErr;
    set2[F2_ENCODE] = rxEvents.encodeErr;
    set2[F2_LINELEN] = rxEvents.lineLenChg;
    setVin = RST_BYTE;
    setVin[VIN_ERR_W-1:0] = videoInErr;
    setVout = RST_BYTE;
    setVout[VOUT_PASS_SET] = passS2_ff & ~passPrev_ff;
    setVout[VOUT_PASS_CLR] = ~passS2_ff & passPrev_ff;
    setVout[VOUT_RX_IRQ] = rxIrq & ~rxIrqPrev_ff;
    nxt_sts1Flags = flagUpd(sts1Flags_ff, set1, rdSts1);
    nxt_sts2Flags = flagUpd(sts2Flags_ff, set2, rdSts2);
    nxt_vinFlags = flagUpd(vinFlags_ff, setVin, rdVin);
    nxt_gpioFlags = flagUpd(gpioFlags_ff, gpioHit, rdGpio);
    // clearing a mask bit also wipes its flag, so it reads zero
    nxt_riseFlags = flagUpd(riseFlags_ff, senRise, rdRise) & riseMask_ff;
    nxt_fallFlags = flagUpd(fallFlags_ff, senFall, rdFall) & fallMask_ff;
    nxt_voutFlags = flagUpd(voutFlags_ff, setVout, rdVout);
  end

  // a pin that is already high at reset release shows up as a change flag
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sts1Flags_ff <= RST_BYTE;
      sts2Flags_ff <= RST_BYTE;
      vinFlags_ff <= RST_BYTE;
      gpioFlags_ff <= RST_BYTE;
      riseFlags_ff <= RST_BYTE;
      fallFlags_ff <= RST_BYTE;
      voutFlags_ff <= RST_BYTE;
    end else begin
      sts1Flags_ff <= nxt_sts1Flags;
      sts2Flags_ff <= nxt_sts2Flags;
      vinFlags_ff <= nxt_vinFlags;
      gpioFlags_ff <= nxt_gpioFlags;
      riseFlags_ff <= nxt_riseFlags;
      fallFlags_ff <= nxt_fallFlags;
      voutFlags_ff <= nxt_voutFlags;
    end
  end

  // flag views and aggregation
  // mirrors are wiring of the same flops, so they never disagree with status one and two
  logic [7:0] isrLo, isrHi, sts1View, sts2View, voutView, summary;
  logic sensorChange, voutIrq, irqAllowed;

  always_comb begin
    sensorChange = |riseFlags_ff || |fallFlags_ff;
    isrLo = {1'b0, sts2Flags_ff[F2_LINELEN], sts2Flags_ff[F2_LINECNT],
             sts2Flags_ff[F2_BUFFER], |vinFlags_ff, sts1Flags_ff[F1_PARITY],
             sts1Flags_ff[F1_PASSCHG], sts1Flags_ff[F1_LOCKCHG]};
    isrHi = {3'b000, |gpioFlags_ff, sensorChange, sts2Flags_ff[F2_ENCODE],
             sts1Flags_ff[F1_SEQ], sts1Flags_ff[F1_CRC]};
    sts1View = {RX_PORT_NUM, sts1Flags_ff[F1_CRC], sts1Flags_ff[F1_LOCKCHG],
                sts1Flags_ff[F1_SEQ], sts1Flags_ff[F1_PARITY], passS2_ff, lockS2_ff};
    sts2View = {rxEvents.lineLenUnstable, sts2Flags_ff[F2_LINELEN], sts2Flags_ff[F2_ENCODE],
                sts2Flags_ff[F2_BUFFER], |vinFlags_ff, rxEvents.freqStable,
                rxEvents.noLinkClk, sts2Flags_ff[F2_LINECNT]};
    voutView = voutFlags_ff;
    voutView[VOUT_PASS_LVL] = passS2_ff;
    // receive-port flag: any flag whose own enable is set
    rxIrq = |(isrLo & icrLo_ff) || |(isrHi & icrHi_ff);
    voutIrq = |(voutFlags_ff & voutIcr_ff);
    // summary source bits ignore the global enable so polling still works; SUM_GLOBAL follows it
    summary = RST_BYTE;
    summary[SUM_RX] = rxIrq && ctl_ff[CTL_RX_EN];
    summary[SUM_VOUT] = voutIrq && ctl_ff[CTL_VOUT_EN];
    irqAllowed = ctl_ff[CTL_GLOBAL_EN] &&
                 (summary[SUM_RX] || summary[SUM_VOUT]);
    summary[SUM_GLOBAL] = irqAllowed;
  end

  // register read port
  // status reads pass through this mux; the matching clear is done in the flag block
  logic [7:0] rdMux;

  // one cycle of read latency; unmapped offsets read 0x00
  always_comb begin
    rdMux = RST_BYTE;
    unique case (regReq.addr)
      ADDR_IRQ_CONTROL: rdMux = ctl_ff;
      ADDR_IRQ_SUMMARY: rdMux = summary;
      ADDR_VOUT_IRQ_ENABLE: rdMux = voutIcr_ff;
      ADDR_VOUT_IRQ_STATUS: rdMux = voutView;
      ADDR_RX_STATUS_ONE: rdMux = sts1View;
      ADDR_RX_STATUS_TWO: rdMux = sts2View;
      ADDR_RX_IRQ_ENABLE_HIGH: rdMux = icrHi_ff;
      ADDR_RX_IRQ_ENABLE_LOW: rdMux = icrLo_ff;
      ADDR_RX_IRQ_FLAGS_HIGH: rdMux = isrHi;
      ADDR_RX_IRQ_FLAGS_LOW: rdMux = isrLo;
      ADDR_GPIO_EDGE_ENABLE: rdMux = gpioIcr_ff;
      ADDR_GPIO_EDGE_STATUS: rdMux = gpioFlags_ff;
      ADDR_SENSOR_BYTE0: rdMux = sensorStatus[7:0];
      ADDR_SENSOR_BYTE1: rdMux = sensorStatus[15:8];
      ADDR_SENSOR_BYTE2: rdMux = sensorStatus[23:16];
      ADDR_SENSOR_BYTE3: rdMux = sensorStatus[31:24];
      ADDR_SENSOR_RISE_MASK: rdMux = riseMask_ff;
      ADDR_SENSOR_FALL_MASK: rdMux = fallMask_ff;
      ADDR_SENSOR_RISE_FLAGS: rdMux = riseFlags_ff & riseMask_ff;
      ADDR_SENSOR_FALL_FLAGS: rdMux = fallFlags_ff & fallMask_ff;
      ADDR_PIN_OUTPUT_SELECT: rdMux = {{(8-GPIO_CNT){1'b0}}, pinSel_ff};
      ADDR_VIDEO_IN_ERROR: rdMux = vinFlags_ff;
      default: rdMux = RST_BYTE;
    endcase
  end

  // registered outputs
  // every pin leaves a flop, so none glitches while several flags update at once
  logic [7:0] rdData_ff, nxt_rdData;
  logic rdValid_ff, nxt_rdValid, irqN_ff, nxt_irqN;
  logic [GPIO_CNT-1:0] gpioOut_ff, gpioOe_ff, nxt_gpioOut, nxt_gpioOe;

  // the read data is the value before the clearing edge, so nothing is lost
  always_comb begin
    nxt_rdData = regReq.rd ? rdMux : rdData_ff;
    nxt_rdValid = regReq.rd;
    nxt_irqN = ~irqAllowed;
    // selected pins drive the combined interrupt low, like the dedicated pin;
    // unselected pins idle high, so selecting one later cannot glitch it low
    nxt_gpioOut = ~pinSel_ff | {GPIO_CNT{~irqAllowed}};
    nxt_gpioOe = pinSel_ff;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdData_ff <= RST_BYTE;
      rdValid_ff <= 1'b0;
      irqN_ff <= 1'b1;
      gpioOut_ff <= '1;
      gpioOe_ff <= '0;
    end else begin
      rdData_ff <= nxt_rdData;
      rdValid_ff <= nxt_rdValid;
      irqN_ff <= nxt_irqN;
      gpioOut_ff <= nxt_gpioOut;
      gpioOe_ff <= nxt_gpioOe;
    end
  end

  assign regRdData = rdData_ff;
  assign regRdValid = rdValid_ff;
  assign irq_out_n = irqN_ff;
  assign gpioOut = gpioOut_ff;
  assign gpioOe = gpioOe_ff;

endmodule : deser_interrupt_aggregator

// file: deser_interrupt_aggregator_bench.sv
// self-checking bench for the interrupt aggregator
`timescale 1ns/10ps
module deser_interrupt_aggregator_bench;
  import deser_irq_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  reg_req_t regReq;
  logic [7:0] regRdData;
  logic regRdValid;
  logic [9:0] evVec = '0;
  logic [3:0] videoInErr = '0;
  logic [31:0] sensorStatus = '0;
  logic rxLockPin = 1'b0;
  logic rxPassPin = 1'b0;
  logic [3:0] remoteGpio = '0;
  logic irq_out_n;
  logic [3:0] gpioOut;
  logic [3:0] gpioOe;
  logic [7:0] got;
  logic [31:0] rnd;
  int seed = 32'h4AB21DCC;
  int badCount = 0;
  int checksDone = 0;
  // event k: clearing register and bit, flag-copy register and bit
  logic [7:0] stReg [7] = '{8'h4D, 8'h4D, 8'h4D, 8'h4E, 8'h4E, 8'h4E, 8'h4E};
  int stBit [7] = '{5, 3, 2, 5, 4, 6, 0};
  logic [7:0] mirReg [7] = '{8'hDA, 8'hDA, 8'hDB, 8'hDA, 8'hDB, 8'hDB, 8'hDB};
  int mirBit [7] = '{0, 1, 2, 2, 4, 6, 5};

  always #25 core_clk = ~core_clk;

  deser_interrupt_aggregator i_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .regReq(regReq), .regRdData(regRdData),
    .regRdValid(regRdValid), .rxEvents(rx_events_t'(evVec)), .videoInErr(videoInErr),
    .sensorStatus(sensorStatus), .rxLockPin(rxLockPin), .rxPassPin(rxPassPin),
    .remoteGpio(remoteGpio), .irq_out_n(irq_out_n), .gpioOut(gpioOut), .gpioOe(gpioOe));

  host_reg_model i_host (
    .core_clk(core_clk), .regReq(regReq), .regRdData(regRdData), .regRdValid(regRdValid));

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checksDone++;
    if (seen !== want) begin
      badCount++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic rdChk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    i_host.rd(a, got);
    check(got & m, e);
  endtask : rdChk

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  // one-cycle event pulse on source k
  task automatic pulse(input int k);
    @(posedge core_clk);
    evVec[9-k] <= 1'b1;
    @(posedge core_clk);
    evVec[9-k] <= 1'b0;
  endtask : pulse

  task automatic finalReport();
    $display("comparisons %0d, mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finalReport

  // run is a few hundred cycles; a hang ends here after 6000
  initial begin
    cyc(6000);
    badCount++;
    finalReport();
  end

  initial begin
    cyc(2);
    sys_rst <= 1'b0;
    rdChk(ADDR_IRQ_CONTROL, 8'hFF, 8'h00);
    rdChk(8'hF0, 8'hFF, 8'h00);
    i_host.put(1'b1, ADDR_RX_IRQ_FLAGS_HIGH, 8'hFF);
    rdChk(ADDR_RX_IRQ_FLAGS_HIGH, 8'hFF, 8'h00);
    // flag latches although its own enable is clear
    i_host.put(1'b1, ADDR_IRQ_CONTROL, 8'h81);
    rdChk(ADDR_IRQ_CONTROL, 8'hFF, 8'h81);
    pulse(1);
    cyc(3);
    check({7'h0, irq_out_n}, 8'h01);
    rdChk(ADDR_RX_IRQ_FLAGS_HIGH, 8'h02, 8'h02);
    rdChk(ADDR_RX_STATUS_ONE, 8'hC8, 8'h08);
    // per-source enable set but global enable clear
    i_host.put(1'b1, ADDR_IRQ_CONTROL, 8'h01);
    i_host.put(1'b1, ADDR_RX_IRQ_ENABLE_HIGH, 8'h01);
    rdChk(ADDR_RX_IRQ_ENABLE_HIGH, 8'hFF, 8'h01);
    pulse(0);
    cyc(3);
    rdChk(ADDR_IRQ_SUMMARY, 8'h81, 8'h01);
    check({7'h0, irq_out_n}, 8'h01);
    i_host.put(1'b1, ADDR_IRQ_CONTROL, 8'h81);
    i_host.put(1'b1, ADDR_PIN_OUTPUT_SELECT, 8'h08);
    cyc(2);
    check({7'h0, irq_out_n}, 8'h00);
    check({gpioOe, gpioOut}, 8'h87);
    rdChk(ADDR_RX_IRQ_FLAGS_HIGH, 8'h01, 8'h01);
    rdChk(ADDR_RX_STATUS_ONE, 8'h20, 8'h20);
    cyc(1);
    check({7'h0, irq_out_n}, 8'h01);
    // every receive-port event: copy, clearing read, copy again
    i_host.put(1'b1, ADDR_RX_IRQ_ENABLE_HIGH, 8'hFF);
    i_host.put(1'b1, ADDR_RX_IRQ_ENABLE_LOW, 8'hFF);
    for (int k = 0; k < 7; k++) begin
      pulse(k);
      cyc(3);
      check({7'h0, irq_out_n}, 8'h00);
      rdChk(mirReg[k], 8'h01 << mirBit[k], 8'h01 << mirBit[k]);
      rdChk(stReg[k], 8'h01 << stBit[k], 8'h01 << stBit[k]);
      rdChk(mirReg[k], 8'h01 << mirBit[k], 8'h00);
      cyc(1);
      check({7'h0, irq_out_n}, 8'h01);
    end
    // event in the same cycle as the clearing read survives it
    fork
      rdChk(ADDR_RX_STATUS_ONE, 8'h04, 8'h00);
      pulse(2);
    join
    rdChk(ADDR_RX_STATUS_ONE, 8'h04, 8'h04);
    rdChk(ADDR_RX_STATUS_ONE, 8'h04, 8'h00);
    // remote pins stay still until edge detection is enabled
    i_host.put(1'b1, ADDR_GPIO_EDGE_ENABLE, 8'h21);
    @(posedge core_clk);
    remoteGpio <= 4'h7;
    cyc(6);
    remoteGpio <= 4'h5; // pulses far above the minimum width
    cyc(6);
    rdChk(ADDR_GPIO_EDGE_STATUS, 8'h0F, 8'h03);
    rdChk(ADDR_GPIO_EDGE_STATUS, 8'h0F, 8'h00);
    // sensor byte zero: bit 0 rise and bit 1 fall masked in
    i_host.put(1'b1, ADDR_SENSOR_RISE_MASK, 8'h01);
    i_host.put(1'b1, ADDR_SENSOR_FALL_MASK, 8'h02);
    @(posedge core_clk);
    sensorStatus <= 32'hC3A55A03;
    cyc(3);
    sensorStatus <= 32'hC3A55A01;
    cyc(3);
    rdChk(ADDR_RX_IRQ_FLAGS_HIGH, 8'h08, 8'h08);
    rdChk(ADDR_SENSOR_RISE_FLAGS, 8'hFF, 8'h01);
    rdChk(ADDR_SENSOR_FALL_FLAGS, 8'hFF, 8'h02);
    rdChk(ADDR_SENSOR_BYTE3, 8'hFF, 8'hC3);
    rdChk(ADDR_SENSOR_RISE_FLAGS, 8'hFF, 8'h00);
    // pass and lock pins rise
    i_host.put(1'b1, ADDR_VOUT_IRQ_ENABLE, 8'h01);
    @(posedge core_clk);
    rxPassPin <= 1'b1;
    rxLockPin <= 1'b1;
    cyc(8);
    rdChk(ADDR_VOUT_IRQ_STATUS, 8'h17, 8'h15);
    rdChk(ADDR_RX_STATUS_ONE, 8'h13, 8'h13);
    // pass falls with the video-out port and its summary bit enabled
    i_host.put(1'b1, ADDR_VOUT_IRQ_ENABLE, 8'h02);
    i_host.put(1'b1, ADDR_IRQ_CONTROL, 8'h91);
    @(posedge core_clk);
    rxPassPin <= 1'b0;
    cyc(8);
    rdChk(ADDR_IRQ_SUMMARY, 8'h91, 8'h91);
    rdChk(ADDR_VOUT_IRQ_STATUS, 8'h17, 8'h06);
    rdChk(ADDR_RX_IRQ_FLAGS_LOW, 8'h03, 8'h02);
    rdChk(ADDR_RX_STATUS_ONE, 8'h03, 8'h01);
    rdChk(ADDR_IRQ_SUMMARY, 8'h91, 8'h00);
    // random live levels and video-in errors
    repeat (4) begin
      rnd = $random(seed);
      @(posedge core_clk);
      evVec[2:0] <= rnd[2:0];
      videoInErr <= rnd[7:4];
      @(posedge core_clk);
      videoInErr <= 4'h0;
      cyc(2);
      rdChk(ADDR_RX_STATUS_TWO, 8'h86, {rnd[2], 4'h0, rnd[1:0], 1'b0});
      rdChk(ADDR_VIDEO_IN_ERROR, 8'h0F, {4'h0, rnd[7:4]});
    end
    finalReport();
  end
endmodule : deser_interrupt_aggregator_bench

// file: deser_irq_checker_assertions.sv
// port-level assertions for the interrupt aggregator
`timescale 1ns/10ps
module deser_irq_checker
  import deser_irq_pkg::*;
#(
  parameter int GPIO_CNT = 4
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire deser_irq_pkg::reg_req_t regReq,
  input wire logic [deser_irq_pkg::DATA_W-1:0] regRdData,
  input wire logic regRdValid,
  input wire deser_irq_pkg::rx_events_t rxEvents,
  input wire logic [deser_irq_pkg::VIN_ERR_W-1:0] videoInErr,
  input wire logic [31:0] sensorStatus,
  input wire logic rxLockPin,
  input wire logic rxPassPin,
  input wire logic [GPIO_CNT-1:0] remoteGpio,
  input wire logic irq_out_n,
  input wire logic [GPIO_CNT-1:0] gpioOut,
  input wire logic [GPIO_CNT-1:0] gpioOe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // read port answers exactly once, one cycle later
  a_read_answers: assert property (regReq.rd |=> regRdValid)
    else $error("read not answered next cycle");
  a_no_stray_valid: assert property (!regReq.rd |=> !regRdValid)
    else $error("read valid without a read");
  a_port_number: assert property (regReq.rd && regReq.addr == ADDR_RX_STATUS_ONE
    |=> regRdData[7:6] == RX_PORT_NUM)
    else $error("status one port number wrong");
  a_unmapped_zero: assert property (regReq.rd && regReq.addr == 8'hF0 |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  // routed pins carry the same active-low level as the dedicated output
  a_pin_follows: assert property (gpioOut == (~gpioOe | {GPIO_CNT{irq_out_n}}))
    else $error("routed pin differs from interrupt output");
  a_global_off: assert property (regReq.wr && regReq.addr == ADDR_IRQ_CONTROL
    && !regReq.wdata[CTL_GLOBAL_EN] |-> ##2 irq_out_n)
    else $error("interrupt active with global enable clear");
  a_release_cause: assert property ($rose(irq_out_n)
    |-> $past(regReq.rd, 2) || $past(regReq.wr) || $past(regReq.wr, 2))
    else $error("interrupt released without a register access");
  a_reset_quiet: assert property (disable iff (1'b0)
    sys_rst |=> irq_out_n && !regRdValid && gpioOe == '0)
    else $error("outputs active after reset");

  c_irq_fired: cover property ($fell(irq_out_n));
  c_status_read: cover property (regReq.rd && regReq.addr == ADDR_RX_STATUS_ONE);
  c_pin_routed: cover property (gpioOe != '0 && !irq_out_n);
endmodule : deser_irq_checker

bind deser_interrupt_aggregator deser_irq_checker #(.GPIO_CNT(GPIO_CNT)) i_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .regReq(regReq), .regRdData(regRdData),
  .regRdValid(regRdValid), .rxEvents(rxEvents), .videoInErr(videoInErr),
  .sensorStatus(sensorStatus), .rxLockPin(rxLockPin), .rxPassPin(rxPassPin),
  .remoteGpio(remoteGpio), .irq_out_n(irq_out_n), .gpioOut(gpioOut), .gpioOe(gpioOe));

// file: deser_irq_pkg.sv
// register map, field layout and carrier types for the interrupt aggregator
package deser_irq_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [7:0] ADDR_IRQ_CONTROL = 8'h23;
  localparam logic [7:0] ADDR_IRQ_SUMMARY = 8'h24;
  localparam logic [7:0] ADDR_VOUT_IRQ_ENABLE = 8'h36;
  localparam logic [7:0] ADDR_VOUT_IRQ_STATUS = 8'h37;
  localparam logic [7:0] ADDR_RX_STATUS_ONE = 8'h4D;
  localparam logic [7:0] ADDR_RX_STATUS_TWO = 8'h4E;
  localparam logic [7:0] ADDR_RX_IRQ_ENABLE_HIGH = 8'hD8;
  localparam logic [7:0] ADDR_RX_IRQ_ENABLE_LOW = 8'hD9;
  localparam logic [7:0] ADDR_RX_IRQ_FLAGS_HIGH = 8'hDA;
  localparam logic [7:0] ADDR_RX_IRQ_FLAGS_LOW = 8'hDB;
  localparam logic [7:0] ADDR_GPIO_EDGE_ENABLE = 8'hE0;
  localparam logic [7:0] ADDR_GPIO_EDGE_STATUS = 8'hE1;
  localparam logic [7:0] ADDR_SENSOR_BYTE0 = 8'hE2;
  localparam logic [7:0] ADDR_SENSOR_BYTE1 = 8'hE3;
  localparam logic [7:0] ADDR_SENSOR_BYTE2 = 8'hE4;
  localparam logic [7:0] ADDR_SENSOR_BYTE3 = 8'hE5;
  localparam logic [7:0] ADDR_SENSOR_RISE_MASK = 8'hE6;
  localparam logic [7:0] ADDR_SENSOR_FALL_MASK = 8'hE7;
  localparam logic [7:0] ADDR_SENSOR_RISE_FLAGS = 8'hE8;
  localparam logic [7:0] ADDR_SENSOR_FALL_FLAGS = 8'hE9;
  localparam logic [7:0] ADDR_PIN_OUTPUT_SELECT = 8'hEA;
  localparam logic [7:0] ADDR_VIDEO_IN_ERROR = 8'hEB;

  // irq_control / irq_summary bit positions
  localparam int CTL_GLOBAL_EN = 7;
  localparam int CTL_VOUT_EN = 4;
  localparam int CTL_RX_EN = 0;
  localparam int SUM_GLOBAL = 7;
  localparam int SUM_VOUT = 4;
  localparam int SUM_RX = 0;

  // video out irq enable / status bit positions
  localparam int VOUT_PASS_SET = 0;
  localparam int VOUT_PASS_CLR = 1;
  localparam int VOUT_RX_IRQ = 2;
  localparam int VOUT_PASS_LVL = 4;

  localparam logic [1:0] RX_PORT_NUM = 2'h0;
  localparam int NUM_GPIO = 4;
  localparam int VIN_ERR_W = 4;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_NIBBLE = 4'h0;

  // event and level sources from the receive port, all on core_clk
  typedef struct packed {
    logic bccCrcErr;
    logic bccSeqErr;
    logic parityErr;
    logic encodeErr;
    logic bufferErr;
    logic lineLenChg;
    logic lineCntChg;
    logic lineLenUnstable;
    logic freqStable;
    logic noLinkClk;
  } rx_events_t;

  // one register access, one cycle wide
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

endpackage : deser_irq_pkg

// file: host_reg_model.sv
// host side model issuing register reads and writes to the aggregator
`timescale 1ns/10ps
module host_reg_model
  import deser_irq_pkg::*;
(
  input wire logic core_clk,
  output deser_irq_pkg::reg_req_t regReq,
  input wire logic [deser_irq_pkg::DATA_W-1:0] regRdData,
  input wire logic regRdValid
);
  initial regReq = '0;

  // one request held across one sampling edge, then released
  task automatic put(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regReq <= '{wr: wr, rd: !wr, addr: a, wdata: d};
    @(posedge core_clk);
    regReq <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d}; // idle bus shows no stale address
  endtask : put

  // reading a status register is also what clears its flags
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    d = 8'hXX;
    put(1'b0, a, 8'h00);
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      if (regRdValid === 1'b1) begin
        d = regRdData;
        break;
      end
    end
  endtask : rd
endmodule : host_reg_model
